/* verilog/sec_bus_cfg_pkg.sv */
// Purpose: constants and carrier types for the secondary bus config/status bank
// Assumes: byte addresses of 32-bit configuration dwords
// Notes: shared by the register bank and its bench
package sec_bus_cfg_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_IRQ_CFG = 8'h7c;
  localparam logic [7:0] ADDR_CAP_STS = 8'h80;
  localparam logic [7:0] ADDR_EVT_STS = 8'ha0;
  localparam logic [7:0] ADDR_EVT_MASK = 8'ha4;
  // fixed values
  localparam logic [7:0] CAP_ID_VAL = 8'h07;
  localparam logic [7:0] NEXT_CAP_VAL = 8'h90;
  localparam logic [7:0] PIN_FWD_VAL = 8'h01;
  localparam logic [7:0] PIN_REV_VAL = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // field positions in the 0x7c dword
  localparam int ROUTE_LSB = 0;
  localparam int PIN_LSB = 8;
  localparam int MIN_BURST_LSB = 16;
  localparam int ACC_INT_LSB = 24;
  // field positions in the 0x80 dword
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_CAP_LSB = 8;
  localparam int BIT_64BIT = 16;
  localparam int BIT_HISPEED = 17;
  localparam int BIT_SC_DISCARD = 18;
  localparam int BIT_SC_UNEXP = 19;
  localparam int BIT_SC_OVERRUN = 20;
  localparam int BIT_SR_DELAYED = 21;
  localparam int CLK_CODE_LSB = 22;
  // index of each event inside the 4-bit flag groups
  localparam int EV_DISCARD = 0;
  localparam int EV_UNEXP = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_DELAYED = 3;
  // secondary clock codes
  localparam logic [2:0] CLK_CONV = 3'h0;
  localparam logic [2:0] CLK_66 = 3'h1;
  localparam logic [2:0] CLK_133 = 3'h2;
  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // event pulses from the bridge core
  typedef struct packed {
    logic sc_discard;
    logic sc_unexpected;
    logic [15:0] sc_requester_id;
    logic sc_overrun;
    logic sr_delayed;
  } core_evt_t;
endpackage

/* verilog/secondary_bus_config_status_regs.sv */
// Purpose: secondary bus interrupt config, capability header and split status
// Assumes: core inputs synchronous to mclk; mode strap stable around reset
// Notes: read data appear the cycle after the read strobe
`timescale 1ns/1ps
module secondary_bus_config_status_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire sec_bus_cfg_pkg::bus_req_t bus_req,
  output logic [31:0] rdata,
  // bridge core side
  input wire logic forward_mode_strap,
  input wire logic [15:0] own_requester_id,
  input wire logic [7:0] min_burst_value,
  input wire logic [7:0] access_interval_value,
  input wire logic [2:0] sec_clk_code,
  input wire sec_bus_cfg_pkg::core_evt_t core_evt,
  // outputs to the core and system
  output logic forward_mode,
  output logic [7:0] irq_routing,
  output logic irq
);

  typedef struct packed {
    logic fwd;
    logic strap_done;
    logic [7:0] routing;
    logic [7:0] min_burst;
    logic [7:0] access_int;
    logic [2:0] clk_code;
    logic [3:0] sts;
    logic [3:0] evt_sts;
    logic [3:0] evt_mask;
    logic [31:0] rdata;
    logic irq;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [3:0] set_vec;
  logic [3:0] sts_clr;
  logic [3:0] evt_clr;
  logic unexp_match;

  // sticky flag update: set beats clear
  function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] set,
                                     input logic [3:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction

  // gather status flags from their 0x80 bit positions
  function automatic logic [3:0] sts_from_word(input logic [31:0] w);
    sts_from_word = {w[sec_bus_cfg_pkg::BIT_SR_DELAYED], w[sec_bus_cfg_pkg::BIT_SC_OVERRUN],
                     w[sec_bus_cfg_pkg::BIT_SC_UNEXP], w[sec_bus_cfg_pkg::BIT_SC_DISCARD]};
  endfunction

  // compose read value for an address
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = sec_bus_cfg_pkg::WORD_ZERO;
    case (a)
      sec_bus_cfg_pkg::ADDR_IRQ_CFG: begin
        w[sec_bus_cfg_pkg::ROUTE_LSB +: 8] = s.routing;
        w[sec_bus_cfg_pkg::PIN_LSB +: 8] = s.fwd ? sec_bus_cfg_pkg::PIN_FWD_VAL :
                                           sec_bus_cfg_pkg::PIN_REV_VAL;
        w[sec_bus_cfg_pkg::MIN_BURST_LSB +: 8] = s.min_burst;
        w[sec_bus_cfg_pkg::ACC_INT_LSB +: 8] = s.access_int;
      end
      sec_bus_cfg_pkg::ADDR_CAP_STS: begin
        w[sec_bus_cfg_pkg::CAP_ID_LSB +: 8] = sec_bus_cfg_pkg::CAP_ID_VAL;
        w[sec_bus_cfg_pkg::NEXT_CAP_LSB +: 8] = sec_bus_cfg_pkg::NEXT_CAP_VAL;
        w[sec_bus_cfg_pkg::BIT_64BIT] = 1'b0;
        w[sec_bus_cfg_pkg::BIT_HISPEED] = s.fwd;
        w[sec_bus_cfg_pkg::BIT_SC_DISCARD] = s.sts[sec_bus_cfg_pkg::EV_DISCARD];
        w[sec_bus_cfg_pkg::BIT_SC_UNEXP] = s.sts[sec_bus_cfg_pkg::EV_UNEXP];
        w[sec_bus_cfg_pkg::BIT_SC_OVERRUN] = s.sts[sec_bus_cfg_pkg::EV_OVERRUN];
        w[sec_bus_cfg_pkg::BIT_SR_DELAYED] = s.sts[sec_bus_cfg_pkg::EV_DELAYED];
        w[sec_bus_cfg_pkg::CLK_CODE_LSB +: 3] = s.clk_code;
      end
      sec_bus_cfg_pkg::ADDR_EVT_STS: begin
        w[3:0] = s.evt_sts;
      end
      sec_bus_cfg_pkg::ADDR_EVT_MASK: begin
        w[3:0] = s.evt_mask;
      end
      default: begin
        w = sec_bus_cfg_pkg::WORD_ZERO;
      end
    endcase
    read_word = w;
  endfunction

  // requester id of an unexpected completion must name this bridge
  assign unexp_match = core_evt.sc_unexpected &&
                       (core_evt.sc_requester_id == own_requester_id);

  // next state
  always_comb begin
    st_next = st_reg;
    set_vec = sec_bus_cfg_pkg::FLAGS_RST;
    sts_clr = sec_bus_cfg_pkg::FLAGS_RST;
    evt_clr = sec_bus_cfg_pkg::FLAGS_RST;
    // mode strap taken once, the first cycle after reset release
    if (!st_reg.strap_done) begin
      st_next.fwd = forward_mode_strap;
      st_next.strap_done = 1'b1;
    end
    // mode-qualified read-only values, zero in reverse mode
    if (st_reg.strap_done && st_reg.fwd) begin
      st_next.min_burst = min_burst_value;
      st_next.access_int = access_interval_value;
      if (sec_clk_code == sec_bus_cfg_pkg::CLK_66 || sec_clk_code == sec_bus_cfg_pkg::CLK_133) begin
        st_next.clk_code = sec_clk_code;
      end else begin
        st_next.clk_code = sec_bus_cfg_pkg::CLK_CONV;
      end
    end else begin
      st_next.min_burst = sec_bus_cfg_pkg::BYTE_ZERO;
      st_next.access_int = sec_bus_cfg_pkg::BYTE_ZERO;
      st_next.clk_code = sec_bus_cfg_pkg::CLK_CONV;
    end
    // event qualification by mode
    if (st_reg.strap_done) begin
      set_vec[sec_bus_cfg_pkg::EV_DISCARD] = st_reg.fwd && core_evt.sc_discard;
      set_vec[sec_bus_cfg_pkg::EV_UNEXP] = !st_reg.fwd && unexp_match;
      set_vec[sec_bus_cfg_pkg::EV_OVERRUN] = core_evt.sc_overrun;
      set_vec[sec_bus_cfg_pkg::EV_DELAYED] = core_evt.sr_delayed;
    end
    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        sec_bus_cfg_pkg::ADDR_IRQ_CFG: begin
          if (st_reg.fwd) begin
            st_next.routing = bus_req.wdata[sec_bus_cfg_pkg::ROUTE_LSB +: 8];
          end
        end
        sec_bus_cfg_pkg::ADDR_CAP_STS: begin
          sts_clr = sts_from_word(bus_req.wdata);
        end
        sec_bus_cfg_pkg::ADDR_EVT_STS: begin
          evt_clr = bus_req.wdata[3:0];
        end
        sec_bus_cfg_pkg::ADDR_EVT_MASK: begin
          st_next.evt_mask = bus_req.wdata[3:0];
        end
        default: begin
          st_next.evt_mask = st_reg.evt_mask;
        end
      endcase
    end
    // sticky flags, the mode-illegal ones stay zero
    st_next.sts = w1c(st_reg.sts, set_vec, sts_clr);
    if (!st_reg.fwd) begin
      st_next.sts[sec_bus_cfg_pkg::EV_DISCARD] = 1'b0;
    end else begin
      st_next.sts[sec_bus_cfg_pkg::EV_UNEXP] = 1'b0;
    end
    st_next.evt_sts = w1c(st_reg.evt_sts, set_vec, evt_clr);
    // interrupt level from next flags so it tracks them without lag
    st_next.irq = |(st_next.evt_sts & st_next.evt_mask);
    // read data, valid the cycle after the strobe only
    if (bus_req.rd) begin
      st_next.rdata = read_word(st_reg, bus_req.addr);
    end else begin
      st_next.rdata = sec_bus_cfg_pkg::WORD_ZERO;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg.fwd <= 1'b0;
      st_reg.strap_done <= 1'b0;
      st_reg.routing <= sec_bus_cfg_pkg::BYTE_ZERO;
      st_reg.min_burst <= sec_bus_cfg_pkg::BYTE_ZERO;
      st_reg.access_int <= sec_bus_cfg_pkg::BYTE_ZERO;
      st_reg.clk_code <= sec_bus_cfg_pkg::CLK_CONV;
      st_reg.sts <= sec_bus_cfg_pkg::FLAGS_RST;
      st_reg.evt_sts <= sec_bus_cfg_pkg::FLAGS_RST;
      st_reg.evt_mask <= sec_bus_cfg_pkg::FLAGS_RST;
      st_reg.rdata <= sec_bus_cfg_pkg::WORD_ZERO;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign rdata = st_reg.rdata;
  assign forward_mode = st_reg.fwd;
  assign irq_routing = st_reg.routing;
  assign irq = st_reg.irq;

endmodule

/* tb/sec_bus_cfg_chk.sv */
// Purpose: port-level assertions for the secondary bus config/status bank
// Assumes: single clock domain, nrst async active low
// Notes: bound into the register bank below
`timescale 1ns/1ps
module sec_bus_cfg_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire sec_bus_cfg_pkg::bus_req_t bus_req,
  input wire logic [31:0] rdata,
  // core side
  input wire logic forward_mode_strap,
  input wire logic [15:0] own_requester_id,
  input wire logic [7:0] min_burst_value,
  input wire logic [7:0] access_interval_value,
  input wire logic [2:0] sec_clk_code,
  input wire sec_bus_cfg_pkg::core_evt_t core_evt,
  // outputs
  input wire logic forward_mode,
  input wire logic [7:0] irq_routing,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic r7c;
  logic r80;
  // marks the cycle in which read data of the 0x7c and 0x80 dwords stand
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r7c <= 1'b0;
      r80 <= 1'b0;
    end else begin
      r7c <= bus_req.rd && bus_req.addr == 8'h7c;
      r80 <= bus_req.rd && bus_req.addr == 8'h80;
    end
  end
  property p_cap; r80 |-> rdata[16:0] == 17'h09007 && rdata[31:25] == 7'h00; endproperty
  a_cap: assert property (p_cap) else $error("capability header bad");
  property p_pin; r7c |-> rdata[15:8] == {7'h00, forward_mode}; endproperty
  a_pin: assert property (p_pin) else $error("pin field bad");
  property p_hs; r80 |-> rdata[17] == forward_mode; endproperty
  a_hs: assert property (p_hs) else $error("speed flag bad");
  property p_revz; r7c && !forward_mode |-> rdata[31:16] == 16'h0000; endproperty
  a_revz: assert property (p_revz) else $error("reverse fields not zero");
  property p_clk; r80 && !forward_mode |-> rdata[24:22] == 3'h0; endproperty
  a_clk: assert property (p_clk) else $error("reverse clock code bad");
  property p_ovr; core_evt.sc_overrun ##1 (bus_req.rd && bus_req.addr == 8'h80) |=> rdata[20];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag missing");
  property p_del; core_evt.sr_delayed ##1 (bus_req.rd && bus_req.addr == 8'h80) |=> rdata[21];
  endproperty
  a_del: assert property (p_del) else $error("delayed flag missing");
  property p_route;
    forward_mode && bus_req.wr && bus_req.addr == 8'h7c |=> irq_routing == $past(bus_req.wdata[7:0]);
  endproperty
  a_route: assert property (p_route) else $error("routing not written");
  property p_rrt; !forward_mode && bus_req.wr |=> $stable(irq_routing); endproperty
  a_rrt: assert property (p_rrt) else $error("routing changed in reverse");
  // main scenarios
  c_ovr: cover property (core_evt.sc_overrun && bus_req.wr);
  c_irq: cover property ($rose(irq));
  c_rev: cover property (r80 && !forward_mode);
endmodule
bind secondary_bus_config_status_regs sec_bus_cfg_chk i_sec_bus_cfg_chk (.mclk, .nrst, .bus_req,
  .rdata, .forward_mode_strap, .own_requester_id, .min_burst_value, .access_interval_value,
  .sec_clk_code, .core_evt, .forward_mode, .irq_routing, .irq);

/* tb/tb.sv */
// Purpose: self-checking bench for the secondary bus config/status bank
// Assumes: inputs change by nba at mclk rising edges
// Notes: forward mode first, then a second reset into reverse mode
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic forward_mode_strap = 1'b1;
  sec_bus_cfg_pkg::bus_req_t bus_req = '0;
  sec_bus_cfg_pkg::core_evt_t core_evt = '0;
  logic [15:0] own_requester_id = 16'h1234;
  logic [7:0] min_burst_value = 8'h3c;
  logic [7:0] access_interval_value = 8'hc3;
  logic [2:0] sec_clk_code = 3'h2;
  logic [31:0] rdata, d;
  logic forward_mode, irq, q;
  logic [7:0] irq_routing;
  int n_errors = 0;
  int checked = 0;
  secondary_bus_config_status_regs i_secondary_bus_config_status_regs (.mclk, .nrst, .bus_req,
    .rdata, .forward_mode_strap, .own_requester_id, .min_burst_value, .access_interval_value,
    .sec_clk_code, .core_evt, .forward_mode, .irq_routing, .irq);
  // 125 MHz clock
  always #4 mclk = ~mclk;
  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rst(input logic f);
    forward_mode_strap <= f;
    nrst <= 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  // read data and irq captured off the edge
  task automatic rd(input logic [7:0] a);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
    q = irq;
    @(posedge mclk);
  endtask
  task automatic ev(input logic dc, un, input logic [15:0] id, input logic ov, dl);
    core_evt <= {dc, un, id, ov, dl};
    @(posedge mclk);
    core_evt <= '0;
  endtask
  task automatic t_fwd();
    rst(1'b1);
    rd(8'h7c);
    chk("cfg reset", d, 32'hc33c0100);
    wr(8'h80, 32'hffffffff);
    rd(8'h80);
    chk("cap word", d, 32'h00829007);
    wr(8'h7c, 32'hffffff5a);
    rd(8'h7c);
    chk("routing", d, 32'hc33c015a);
    chk("routing out", 32'(irq_routing), 32'h5a);
    for (int i = 0; i < 8; i++) begin
      sec_clk_code <= i[2:0];
      @(posedge mclk);
      rd(8'h80);
      chk("clock code", 32'(d[24:22]), (i < 3) ? 32'(i) : 32'h0);
    end
    rd(8'h44);
    chk("unmapped", d, 32'h0);
    $display("t_fwd done");
  endtask
  task automatic t_evt();
    wr(8'ha4, 32'hf);
    ev(1'b1, 1'b1, 16'h1234, 1'b1, 1'b1);
    rd(8'h80);
    chk("flags", 32'(d[21:18]), 32'hd);
    chk("irq set", 32'(q), 32'h1);
    wr(8'h80, 32'h00100000);
    rd(8'h80);
    chk("w1c", 32'(d[21:18]), 32'h9);
    core_evt.sc_overrun <= 1'b1;
    wr(8'h80, 32'h00100000);
    core_evt <= '0;
    rd(8'h80);
    chk("set wins", 32'(d[20]), 32'h1);
    wr(8'ha0, 32'hf);
    rd(8'ha0);
    chk("evt clear", {d[31:1], q}, 32'h0);
    wr(8'ha4, 32'h0);
    ev(1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
    rd(8'ha0);
    chk("masked", {d[31:1], q}, 32'h4);
    $display("t_evt done");
  endtask
  task automatic t_rev();
    rst(1'b0);
    wr(8'h7c, 32'h33);
    rd(8'h7c);
    chk("rev cfg", d, 32'h0);
    rd(8'h80);
    chk("rev cap", d, 32'h00009007);
    ev(1'b1, 1'b1, 16'h1235, 1'b0, 1'b0);
    rd(8'h80);
    chk("rev miss", 32'(d[21:18]), 32'h0);
    ev(1'b0, 1'b1, 16'h1234, 1'b0, 1'b0);
    rd(8'h80);
    chk("rev hit", 32'(d[21:18]), 32'h2);
    wr(8'h80, 32'h00080000);
    rd(8'h80);
    chk("rev w1c", 32'(d[21:18]), 32'h0);
    $display("t_rev done");
  endtask
  // main sequence
  initial begin
    t_fwd();
    t_evt();
    t_rev();
    close_out();
  end
  // watchdog
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule
